// ===== fei_frequency_error_indicator.sv
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
module fei_frequency_error_indicator #(
  parameter int unsigned GATE_CYC = fei_pkg::GATE_CYC,
  parameter int unsigned LAMP_TEST_CYC = fei_pkg::LAMP_TEST_CYC,
  parameter int unsigned BLINK_CYC = fei_pkg::BLINK_CYC,
  parameter int unsigned DEBOUNCE_CYC = fei_pkg::DEBOUNCE_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic rfSquareIn,
  output logic injOut,
  output logic injOe,
  input wire logic channelSwitchA_b,
  input wire logic channelSwitchB_b,
  input wire logic orientationJumper_b,
  input wire logic meterSpanJumper_b,
  input wire logic programButton_b,
  output logic [4:0] pullUpEn,
  output logic [4:0] lamp,
  output logic meterPwm,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  fei_pkg::fei_state_type state_r;
  logic rfSync;
  logic rfPrev_r;
  logic rfEdge;
  logic [3:0] ctrlSync;
  logic btnDeb;
  logic btnPrev_r;
  logic pressEvt;
  logic [1:0] chan;
  logic orientOpen;
  logic spanWide;
  logic [31:0] timer_r;
  logic [3:0] settle_r;
  logic [3:0] prescale_r;
  logic [15:0] mainCnt_r;
  logic [15:0] mainSnap_r;
  logic [4:0] toggles_r;
  logic [19:0] measCount_r;
  logic standby_r;
  logic [19:0] ref_r [4];
  logic [19:0] refSel;
  logic signed [20:0] errFull;
  logic signed [10:0] errClip;
  logic signed [21:0] scaled;
  logic [7:0] dutyCalc;
  logic [7:0] duty_r;
  logic [31:0] blinkCnt_r;
  logic blink_r;
  logic [4:0] lampCalc;
  logic apbWrite;
  logic apbSetup;
  logic [23:0] refMerged;
  logic regHit;
  logic regRo;
  logic [31:0] readMux;

  fei_meter_if meterBus ();

  assign pullUpEn = 5'h1F;

  fei_sync_filter #(
    .WIDTH(5),
    .DEB_CYC(1)
  ) u_ctrl_sync (
    .clk(clk),
    .rst_b(rst_b),
    .din({rfSquareIn, meterSpanJumper_b, orientationJumper_b, channelSwitchB_b,
          channelSwitchA_b}),
    .dout({rfSync, ctrlSync})
  );

  fei_sync_filter #(
    .WIDTH(1),
    .DEB_CYC(DEBOUNCE_CYC)
  ) u_button_filter (
    .clk(clk),
    .rst_b(rst_b),
    .din(programButton_b),
    .dout(btnDeb)
  );

  fei_meter_pwm u_meter_pwm (
    .clk(clk),
    .rst_b(rst_b),
    .m(meterBus.gen)
  );

  assign meterBus.duty = duty_r;
  assign meterPwm = meterBus.pwmOut;

  // Open switches read high through the pull-ups
  assign chan = ctrlSync[1:0];
  assign orientOpen = ctrlSync[2];
  assign spanWide = ~ctrlSync[3];
  assign refSel = ref_r[chan];

  // Edge counting; the pin carries either the squarer or our own toggles
  assign rfEdge = rfSync & ~rfPrev_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // Matches the synchroniser's reset level, so reset makes no false edge
      rfPrev_r <= 1'b1;
      btnPrev_r <= 1'b1;
    end else begin
      rfPrev_r <= rfSync;
      btnPrev_r <= btnDeb;
    end
  end

  assign pressEvt = btnPrev_r & ~btnDeb;

  // The sequencer reads this residue only to catch a carry; the count rebuilds it from the toggle tally
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prescale_r <= '0;
      mainCnt_r <= '0;
    end else if (state_r == fei_pkg::ST_CALC) begin
      mainCnt_r <= '0;
      if (rfEdge) begin
        prescale_r <= prescale_r + 4'h1;
      end
    end else if (state_r != fei_pkg::ST_LAMPTEST && rfEdge) begin
      if (prescale_r == fei_pkg::PRESCALE_LAST) begin
        prescale_r <= '0;
        mainCnt_r <= mainCnt_r + 16'h0001;
      end else begin
        prescale_r <= prescale_r + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= fei_pkg::ST_LAMPTEST;
      timer_r <= '0;
      settle_r <= '0;
      toggles_r <= '0;
      mainSnap_r <= '0;
      measCount_r <= '0;
      standby_r <= 1'b1;
      injOut <= 1'b0;
      injOe <= 1'b0;
    end else begin
      case (state_r)
        fei_pkg::ST_LAMPTEST: begin
          if (timer_r >= LAMP_TEST_CYC - 1) begin
            timer_r <= '0;
            state_r <= fei_pkg::ST_GATE;
          end else begin
            timer_r <= timer_r + 32'h1;
          end
        end
        fei_pkg::ST_GATE: begin
          if (timer_r >= GATE_CYC - 1) begin
            timer_r <= '0;
            injOe <= 1'b1;
            injOut <= 1'b0;
            settle_r <= '0;
            toggles_r <= '0;
            state_r <= fei_pkg::ST_INJ_LOW;
          end else begin
            timer_r <= timer_r + 32'h1;
          end
        end
        fei_pkg::ST_INJ_LOW: begin
          if (settle_r == fei_pkg::SETTLE_LAST) begin
            // Snapshot after the settle so edges still in the synchroniser are counted
            if (toggles_r == '0) begin
              mainSnap_r <= mainCnt_r;
            end
            injOut <= 1'b1;
            toggles_r <= toggles_r + 5'h01;
            settle_r <= '0;
            state_r <= fei_pkg::ST_INJ_HIGH;
          end else begin
            settle_r <= settle_r + 4'h1;
          end
        end
        fei_pkg::ST_INJ_HIGH: begin
          if (settle_r == fei_pkg::SETTLE_LAST) begin
            settle_r <= '0;
            injOut <= 1'b0;
            // The pin path is three flops deep, so the carry can land on this very edge
            if (mainCnt_r != mainSnap_r || toggles_r == fei_pkg::PRESCALE ||
                (rfEdge && prescale_r == fei_pkg::PRESCALE_LAST)) begin
              state_r <= fei_pkg::ST_CALC;
            end else begin
              state_r <= fei_pkg::ST_INJ_LOW;
            end
          end else begin
            settle_r <= settle_r + 4'h1;
          end
        end
        fei_pkg::ST_CALC: begin
          // Count in units of 10 Hz; the residue rides below the prescaled count
          measCount_r <= {mainSnap_r, 4'h0} +
                         {15'h0000, fei_pkg::PRESCALE - toggles_r};
          standby_r <= ({mainSnap_r, 4'h0} + {15'h0000, fei_pkg::PRESCALE - toggles_r})
                       < fei_pkg::MIN_CARRIER_COUNT;
          injOe <= 1'b0;
          timer_r <= '0;
          state_r <= fei_pkg::ST_GATE;
        end
        default: begin
          state_r <= fei_pkg::ST_LAMPTEST;
          timer_r <= '0;
          injOe <= 1'b0;
          injOut <= 1'b0;
        end
      endcase
    end
  end

  // Error, orientation and meter scaling
  always_comb begin
    errFull = $signed({1'b0, measCount_r}) - $signed({1'b0, refSel});
    if (!orientOpen) begin
      errFull = -errFull;
    end
    if (errFull > fei_pkg::ERR_LIMIT) begin
      errClip = fei_pkg::ERR_LIMIT[10:0];
    end else if (errFull < -fei_pkg::ERR_LIMIT) begin
      errClip = -fei_pkg::ERR_LIMIT[10:0];
    end else begin
      errClip = errFull[10:0];
    end
    scaled = (errClip * (spanWide ? fei_pkg::SCALE_WIDE : fei_pkg::SCALE_NARROW))
             >>> fei_pkg::SCALE_SHIFT;
    scaled = scaled + $signed({14'h0000, fei_pkg::DUTY_MID});
    if (scaled < 0) begin
      dutyCalc = 8'h00;
    end else if (scaled > $signed({14'h0000, fei_pkg::DUTY_MAX})) begin
      dutyCalc = fei_pkg::DUTY_MAX;
    end else begin
      dutyCalc = scaled[7:0];
    end
  end

  // Lamp windows overlap so neighbouring lamps share the transition
  always_comb begin
    lampCalc = '0;
    if (errClip < -fei_pkg::WIN_OUTER) begin
      lampCalc[fei_pkg::LAMP_LOW_RED] = (errClip < -fei_pkg::WIN_FLASH) ? blink_r : 1'b1;
    end
    if (errClip >= -fei_pkg::WIN_INNER_FAR && errClip <= -fei_pkg::WIN_INNER_NEAR) begin
      lampCalc[fei_pkg::LAMP_LOW] = 1'b1;
    end
    if (errClip >= -fei_pkg::WIN_CENTRE && errClip <= fei_pkg::WIN_CENTRE) begin
      lampCalc[fei_pkg::LAMP_CENTRE] = 1'b1;
    end
    if (errClip >= fei_pkg::WIN_INNER_NEAR && errClip <= fei_pkg::WIN_INNER_FAR) begin
      lampCalc[fei_pkg::LAMP_HIGH] = 1'b1;
    end
    if (errClip > fei_pkg::WIN_OUTER) begin
      lampCalc[fei_pkg::LAMP_HIGH_RED] = (errClip > fei_pkg::WIN_FLASH) ? blink_r : 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      blinkCnt_r <= '0;
      blink_r <= 1'b0;
    end else if (blinkCnt_r >= BLINK_CYC - 1) begin
      blinkCnt_r <= '0;
      blink_r <= ~blink_r;
    end else begin
      blinkCnt_r <= blinkCnt_r + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lamp <= '1;
      duty_r <= fei_pkg::DUTY_MID;
    end else if (state_r == fei_pkg::ST_LAMPTEST) begin
      lamp <= '1;
      duty_r <= fei_pkg::DUTY_MID;
    end else if (standby_r) begin
      lamp <= '0;
      lamp[fei_pkg::LAMP_CENTRE] <= blink_r;
      duty_r <= fei_pkg::DUTY_MID;
    end else begin
      lamp <= lampCalc;
      duty_r <= dutyCalc;
    end
  end

  // Register slave: zero wait states, read data captured in the setup cycle
  assign apbSetup = psel & ~penable;
  assign apbWrite = psel & penable & pwrite;
  assign pready = 1'b1;

  always_comb begin
    regHit = 1'b1;
    regRo = 1'b1;
    readMux = '0;
    case (paddr)
      fei_pkg::ADDR_STATUS: begin
        readMux[fei_pkg::STAT_STANDBY] = standby_r;
        readMux[fei_pkg::STAT_LAMPTEST] = (state_r == fei_pkg::ST_LAMPTEST);
        readMux[fei_pkg::STAT_CHAN_LSB +: 2] = chan;
        readMux[fei_pkg::STAT_ORIENT] = orientOpen;
        readMux[fei_pkg::STAT_SPAN] = spanWide;
      end
      fei_pkg::ADDR_COUNT: begin
        readMux[19:0] = measCount_r;
      end
      fei_pkg::ADDR_ERROR: begin
        readMux = {{21{errClip[10]}}, errClip};
      end
      fei_pkg::ADDR_REF: begin
        readMux[19:0] = refSel;
        regRo = 1'b0;
      end
      fei_pkg::ADDR_DUTY: begin
        readMux[7:0] = duty_r;
      end
      default: begin
        regHit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (apbSetup) begin
      prdata <= pwrite ? 32'h0000_0000 : readMux;
      pslverr <= ~regHit | (pwrite & regRo);
    end
  end

  always_comb begin
    refMerged = {4'h0, refSel};
    for (int i = 0; i < 3; i++) begin
      if (pstrb[i]) begin
        refMerged[i*8 +: 8] = pwdata[i*8 +: 8];
      end
    end
  end

  // A software write in the same cycle as a button press takes precedence
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 4; i++) begin
        ref_r[i] <= '0;
      end
    end else if (apbWrite && paddr == fei_pkg::ADDR_REF) begin
      ref_r[chan] <= refMerged[19:0];
    end else if (pressEvt && !standby_r && state_r != fei_pkg::ST_LAMPTEST) begin
      ref_r[chan] <= measCount_r;
    end
  end

endmodule : fei_frequency_error_indicator

// ===== fei_frequency_error_indicator_assertions.sv
`timescale 1ns/1ps
module fei_frequency_error_indicator_assertions #(
  parameter int unsigned GATE_CYC = 200
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic injOut,
  input wire logic injOe,
  input wire logic [4:0] pullUpEn,
  input wire logic [4:0] lamp,
  input wire logic meterPwm
);
  int lowCnt;
  int highCnt;
  int periodCnt;
  logic seenFall;
  logic seenRise;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // First run after reset is partial, so length checks wait for a full one
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lowCnt <= 0;
      highCnt <= 0;
      periodCnt <= 0;
      seenFall <= 1'b0;
      seenRise <= 1'b0;
    end else begin
      lowCnt <= injOe ? 0 : lowCnt + 1;
      highCnt <= meterPwm ? highCnt + 1 : 0;
      periodCnt <= $rose(meterPwm) ? 1 : periodCnt + 1;
      if ($fell(injOe)) seenFall <= 1'b1;
      if ($rose(meterPwm)) seenRise <= 1'b1;
    end
  end

  lamp_test_a: assert property ($rose(rst_b) |-> (lamp == 5'h1F && !injOe) [*8])
    else $error("lamps not all lit after reset");
  pull_up_a: assert property (pullUpEn == 5'h1F)
    else $error("control pull-ups not enabled");
  inj_low_a: assert property ($rose(injOe) |-> !injOut [*4])
    else $error("injection not driven low at gate end");
  inj_pace_a: assert property (injOe && $past(injOe) && $changed(injOut) |=> $stable(injOut) [*3])
    else $error("injection toggle too fast");
  inj_bound_a: assert property ($rose(injOe) |-> ##[1:200] !injOe)
    else $error("injection never ended");
  gate_len_a: assert property ($rose(injOe) && seenFall |->
      lowCnt >= GATE_CYC - 2 && lowCnt <= GATE_CYC + 2)
    else $error("gate length wrong");
  pwm_step_a: assert property ($fell(meterPwm) |-> highCnt % fei_pkg::PWM_STEP_CYC == 0)
    else $error("pulse width not a whole step");
  pwm_period_a: assert property ($rose(meterPwm) && seenRise |->
      periodCnt % (fei_pkg::PWM_STEP_CYC * fei_pkg::PWM_STEPS) == 0)
    else $error("pwm period wrong");
  lamp_pair_a: assert property ((lamp[1] && lamp[3]) || (lamp[0] && lamp[4]) |->
      lamp == 5'h1F)
    else $error("opposite lamps lit together");

  cover property ($rose(injOe));
  cover property ($fell(meterPwm));
  cover property (lamp == 5'h01);
endmodule : fei_frequency_error_indicator_assertions

// ===== fei_frequency_error_indicator_bench.sv
`timescale 1ns/1ps
module fei_frequency_error_indicator_bench;
  logic clk, rst_b, carrierOn, squareOut, injOut, injOe, rfSquareIn, meterPwm, b;
  logic channelSwitchA_b, channelSwitchB_b, orientationJumper_b, meterSpanJumper_b;
  logic programButton_b, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0] halfCycles, paddr;
  logic [4:0] pullUpEn, lamp;
  logic [31:0] pwdata, prdata, rdata;
  int bad_count, check_count, cnt, ons;

  // The injection pin overrides the squarer whenever it drives
  assign rfSquareIn = injOe ? injOut : squareOut;

  fei_squarer_model fei_squarer_model_inst (.clk(clk), .carrierOn(carrierOn),
    .halfCycles(halfCycles), .squareOut(squareOut));

  fei_frequency_error_indicator #(.GATE_CYC(800), .LAMP_TEST_CYC(50), .BLINK_CYC(20),
    .DEBOUNCE_CYC(4)) fei_frequency_error_indicator_inst (.clk(clk), .rst_b(rst_b),
    .rfSquareIn(rfSquareIn), .injOut(injOut), .injOe(injOe),
    .channelSwitchA_b(channelSwitchA_b), .channelSwitchB_b(channelSwitchB_b),
    .orientationJumper_b(orientationJumper_b), .meterSpanJumper_b(meterSpanJumper_b),
    .programButton_b(programButton_b), .pullUpEn(pullUpEn), .lamp(lamp),
    .meterPwm(meterPwm), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic checkRange(input logic [31:0] seen, input int lo, input int hi);
    logic [31:0] exp;
    exp = 32'(lo);
    if ($signed(seen) >= lo && $signed(seen) <= hi) exp = seen;
    check(seen, exp);
  endtask : checkRange

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      bad_count++;
      summarize();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic waitOe(input logic v);
    int k;
    for (k = 0; k < 2000 && injOe !== v; k++) @(posedge clk);
    if (k == 2000) begin
      bad_count++;
      summarize();
    end
  endtask : waitOe

  // Two gate ends guarantee a measurement taken wholly under the new conditions
  task automatic freshCount;
    repeat (2) begin
      waitOe(1'b1);
      waitOe(1'b0);
    end
  endtask : freshCount

  task automatic lampIs(input logic [4:0] exp);
    @(negedge clk);
    check({27'h0, lamp}, {27'h0, exp});
    @(posedge clk);
  endtask : lampIs

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    summarize();
  end

  initial begin
    rst_b = 1'b0;
    carrierOn = 1'b0;
    halfCycles = 8'h02;
    {channelSwitchA_b, channelSwitchB_b, orientationJumper_b} = 3'h7;
    meterSpanJumper_b = 1'b1;
    programButton_b = 1'b1;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    apb(1'b0, fei_pkg::ADDR_STATUS, 32'h0);
    check(rdata & 32'h2, 32'h2);
    check(rdata & 32'hC, 32'hC);
    repeat (60) @(posedge clk);
    apb(1'b0, fei_pkg::ADDR_STATUS, 32'h0);
    check(rdata & 32'h3, 32'h1);
    apb(1'b0, fei_pkg::ADDR_DUTY, 32'h0);
    check(rdata, 32'h80);
    @(negedge clk);
    b = lamp[2];
    check({27'h0, lamp & 5'h1B}, 32'h0);
    repeat (20) @(negedge clk);
    check({31'h0, lamp[2]}, {31'h0, ~b});
    @(posedge clk);
    apb(1'b0, 8'h14, 32'h0);
    check({rdata[30:0], rerr}, 32'h1);
    apb(1'b1, fei_pkg::ADDR_COUNT, 32'h5);
    check({31'h0, rerr}, 32'h1);
    carrierOn <= 1'b1;
    freshCount();
    apb(1'b0, fei_pkg::ADDR_COUNT, 32'h0);
    cnt = int'(rdata);
    checkRange(rdata, 200, 201);
    {channelSwitchB_b, channelSwitchA_b} <= 2'h0;
    repeat (10) @(posedge clk);
    apb(1'b1, fei_pkg::ADDR_REF, 32'h12345);
    programButton_b <= 1'b0;
    repeat (2) @(posedge clk);
    programButton_b <= 1'b1;
    repeat (10) @(posedge clk);
    apb(1'b0, fei_pkg::ADDR_REF, 32'h0);
    check(rdata, 32'h12345);
    programButton_b <= 1'b0;
    repeat (10) @(posedge clk);
    programButton_b <= 1'b1;
    repeat (10) @(posedge clk);
    apb(1'b0, fei_pkg::ADDR_REF, 32'h0);
    checkRange(rdata, cnt - 1, cnt + 1);
    channelSwitchA_b <= 1'b1;
    repeat (10) @(posedge clk);
    apb(1'b0, fei_pkg::ADDR_STATUS, 32'h0);
    check(rdata & 32'hC, 32'h4);
    apb(1'b1, fei_pkg::ADDR_REF, 32'(cnt - 100));
    freshCount();
    apb(1'b0, fei_pkg::ADDR_ERROR, 32'h0);
    checkRange(rdata, 99, 101);
    lampIs(5'h08);
    repeat (20800) @(posedge clk);
    apb(1'b0, fei_pkg::ADDR_DUTY, 32'h0);
    check(rdata, 32'hFF);
    meterSpanJumper_b <= 1'b0;
    repeat (20800) @(posedge clk);
    apb(1'b0, fei_pkg::ADDR_DUTY, 32'h0);
    checkRange(rdata, 178, 179);
    lampIs(5'h08);
    orientationJumper_b <= 1'b0;
    repeat (20800) @(posedge clk);
    apb(1'b0, fei_pkg::ADDR_DUTY, 32'h0);
    checkRange(rdata, 76, 77);
    lampIs(5'h02);
    orientationJumper_b <= 1'b1;
    apb(1'b1, fei_pkg::ADDR_REF, 32'(cnt + 300));
    freshCount();
    ons = 0;
    repeat (50) begin
      @(negedge clk);
      ons += int'(lamp[0]);
    end
    check({27'h0, lamp & 5'h1E}, 32'h0);
    check(32'(ons > 0 && ons < 50), 32'h1);
    summarize();
  end
endmodule : fei_frequency_error_indicator_bench

bind fei_frequency_error_indicator fei_frequency_error_indicator_assertions #(
  .GATE_CYC(GATE_CYC)) fei_frequency_error_indicator_assertions_inst (.clk(clk),
  .rst_b(rst_b), .injOut(injOut), .injOe(injOe), .pullUpEn(pullUpEn), .lamp(lamp),
  .meterPwm(meterPwm));

// ===== fei_meter_if.sv
`timescale 1ns/1ps
interface fei_meter_if;
  logic [7:0] duty;
  logic pwmOut;
  modport ctl (output duty, input pwmOut);
  modport gen (input duty, output pwmOut);
endinterface : fei_meter_if

// ===== fei_meter_pwm.sv
`timescale 1ns/1ps
module fei_meter_pwm (
  input wire logic clk,
  input wire logic rst_b,
  fei_meter_if.gen m
);

  logic [31:0] div_r;
  logic stepEn;
  logic [7:0] phase_r;
  logic [7:0] dutyHeld_r;

  assign stepEn = (div_r == fei_pkg::PWM_STEP_CYC - 1);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_r <= '0;
    end else if (stepEn) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 32'h1;
    end
  end

  // Duty only changes at the period start, so no runt pulses reach the meter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_r <= '0;
      dutyHeld_r <= fei_pkg::DUTY_MID;
      m.pwmOut <= 1'b0;
    end else if (stepEn) begin
      phase_r <= phase_r + 8'h01;
      if (phase_r == fei_pkg::DUTY_MAX) begin
        dutyHeld_r <= m.duty;
      end
      m.pwmOut <= (phase_r < dutyHeld_r);
    end
  end

endmodule : fei_meter_pwm

// ===== fei_pkg.sv
package fei_pkg;

  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned GATE_MS = 100;
  localparam int unsigned GATE_CYC = CLK_HZ / 1000 * GATE_MS;
  localparam int unsigned LAMP_TEST_MS = 1000;
  localparam int unsigned LAMP_TEST_CYC = CLK_HZ / 1000 * LAMP_TEST_MS;
  localparam int unsigned BLINK_MS = 250;
  localparam int unsigned BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
  localparam int unsigned DEBOUNCE_MS = 20;
  localparam int unsigned DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int unsigned PWM_HZ = 5000;
  localparam int unsigned PWM_STEPS = 256;
  localparam int unsigned PWM_STEP_CYC = CLK_HZ / PWM_HZ / PWM_STEPS;

  localparam logic [3:0] SETTLE_LAST = 4'h3;
  localparam logic [4:0] PRESCALE = 5'h10;
  localparam logic [3:0] PRESCALE_LAST = 4'hF;
  localparam logic [19:0] MIN_CARRIER_COUNT = 20'h00001;

  localparam logic [7:0] DUTY_MID = 8'h80;
  localparam logic [7:0] DUTY_MAX = 8'hFF;
  localparam logic signed [10:0] SCALE_NARROW = 11'sh222;
  localparam logic signed [10:0] SCALE_WIDE = 11'sh083;
  localparam int unsigned SCALE_SHIFT = 8;
  localparam logic signed [20:0] ERR_LIMIT = 21'sh003FF;

  localparam logic signed [10:0] WIN_FLASH = 11'sh0FA;
  localparam logic signed [10:0] WIN_OUTER = 11'sh096;
  localparam logic signed [10:0] WIN_INNER_FAR = 11'sh0C8;
  localparam logic signed [10:0] WIN_INNER_NEAR = 11'sh014;
  localparam logic signed [10:0] WIN_CENTRE = 11'sh032;

  localparam int unsigned LAMP_LOW_RED = 0;
  localparam int unsigned LAMP_LOW = 1;
  localparam int unsigned LAMP_CENTRE = 2;
  localparam int unsigned LAMP_HIGH = 3;
  localparam int unsigned LAMP_HIGH_RED = 4;

  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_COUNT = 8'h04;
  localparam logic [7:0] ADDR_ERROR = 8'h08;
  localparam logic [7:0] ADDR_REF = 8'h0C;
  localparam logic [7:0] ADDR_DUTY = 8'h10;
  localparam int unsigned STAT_STANDBY = 0;
  localparam int unsigned STAT_LAMPTEST = 1;
  localparam int unsigned STAT_CHAN_LSB = 2;
  localparam int unsigned STAT_ORIENT = 4;
  localparam int unsigned STAT_SPAN = 5;

  typedef enum {ST_LAMPTEST, ST_GATE, ST_INJ_LOW, ST_INJ_HIGH, ST_CALC} fei_state_type;

endpackage : fei_pkg

// ===== fei_squarer_model.sv
`timescale 1ns/1ps
// Comparator output: a square wave while a carrier is present, resting low without one
module fei_squarer_model (
  input wire logic clk,
  input wire logic carrierOn,
  input wire logic [7:0] halfCycles,
  output logic squareOut
);
  logic [7:0] phase;
  initial begin
    squareOut = 1'b0;
    phase = 8'h00;
  end
  always @(posedge clk) begin
    if (!carrierOn) begin
      squareOut <= 1'b0;
      phase <= 8'h00;
    end else if (phase >= halfCycles - 8'h01) begin
      squareOut <= ~squareOut;
      phase <= 8'h00;
    end else begin
      phase <= phase + 8'h01;
    end
  end
endmodule : fei_squarer_model

// ===== fei_sync_filter.sv
`timescale 1ns/1ps
// Two-flop synchroniser followed by a stability filter; DEB_CYC of 1 gives a plain sync.
module fei_sync_filter #(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned DEB_CYC = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  logic [31:0] stable_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '1;
      sync_r <= '1;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
    end
  end

  // Idle level is high because every control pin is pulled up
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dout <= '1;
      stable_r <= '0;
    end else if (sync_r == dout) begin
      stable_r <= '0;
    end else if (stable_r >= DEB_CYC - 1) begin
      dout <= sync_r;
      stable_r <= '0;
    end else begin
      stable_r <= stable_r + 32'h1;
    end
  end

endmodule : fei_sync_filter
